// [wdt_pkg.sv]
// Constants, field layout and types of the watchdog timer block.
// Assumes one clock for bus and counter; offsets are byte addresses.
package wdt_pkg;

	// ------------------------------------------------------------
	// Bus geometry and register offsets
	// ------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam int         DATA_W       = 32;
	localparam int         BE_W         = 4;
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_UNLOCK   = 8'h04;
	localparam logic [7:0] OFF_EVT_STAT = 8'h08;
	localparam logic [7:0] OFF_EVT_CLR  = 8'h0C;
	localparam logic [7:0] OFF_EVT_EN   = 8'h10;
	localparam logic [7:0] OFF_COUNT    = 8'h14;

	// ------------------------------------------------------------
	// Unlock sequence
	// ------------------------------------------------------------
	localparam logic [7:0] UNLOCK_KEY1 = 8'h59;
	localparam logic [7:0] UNLOCK_KEY2 = 8'h16;
	localparam logic [7:0] UNLOCK_KEY3 = 8'h88;

	// ------------------------------------------------------------
	// Control register layout, bits [10:0]
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] interval_sel;
		logic       enable;
		logic       irq_en;
		logic       wake_flag;
		logic       wake_en;
		logic       irq_flag;
		logic       reset_flag;
		logic       reset_en;
		logic       clear;
	} wdt_ctrl_type;

	localparam int           CTRL_W     = 11;
	localparam int           LANE_LO_W  = 8;
	localparam wdt_ctrl_type CTRL_RESET = 11'h700;

	// ------------------------------------------------------------
	// Counting
	// ------------------------------------------------------------
	localparam int CNT_W      = 18;
	localparam int SHAMT_W    = 5;
	localparam int SEL_BASE   = 4;
	localparam int SEL_STEP   = 2;
	localparam int GRACE_CLKS = 1024;
	localparam int GRACE_W    = 11;
	localparam int RST_CLKS   = 63;
	localparam int RST_W      = 6;

	// ------------------------------------------------------------
	// Interrupt event bits
	// ------------------------------------------------------------
	localparam int EVT_W       = 3;
	localparam int EVT_TIMEOUT = 0;
	localparam int EVT_WAKE    = 1;
	localparam int EVT_RESET   = 2;

	// ------------------------------------------------------------
	// State machines
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		LK_LOCKED = 4'h1,
		LK_KEY1   = 4'h2,
		LK_KEY2   = 4'h4,
		LK_OPEN   = 4'h8
	} wdt_lock_type;

	typedef enum logic [2:0] {
		WD_RUN   = 3'h1,
		WD_GRACE = 3'h2,
		WD_RESET = 3'h4
	} wdt_state_type;

endpackage : wdt_pkg

// [wdt_top.sv]
// Watchdog timer with write-protected control, Avalon-MM slave and interrupt.
// Assumes bus master, power-down level and counter share clk.
`timescale 1ns/10ps

module wdt_top
	import wdt_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [DATA_W-1:0] avs_writedata,
	input  wire logic [BE_W-1:0]   avs_byteenable,
	output logic [DATA_W-1:0]      avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              power_down,
	output logic                   wdt_irq,
	output logic                   sys_reset_req,
	output logic                   wake_req
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic                wait_reg;
	logic                wait_next;
	logic [DATA_W-1:0]   rdata_reg;
	logic [DATA_W-1:0]   rdata_next;
	wdt_lock_type        lock_reg;
	wdt_lock_type        lock_next;
	wdt_ctrl_type        ctrl_reg;
	wdt_ctrl_type        ctrl_next;
	wdt_state_type       state_reg;
	wdt_state_type       state_next;
	logic [CNT_W-1:0]    cnt_reg;
	logic [CNT_W-1:0]    cnt_next;
	logic [GRACE_W-1:0]  grace_reg;
	logic [GRACE_W-1:0]  grace_next;
	logic [RST_W-1:0]    rst_cnt_reg;
	logic [RST_W-1:0]    rst_cnt_next;
	logic [EVT_W-1:0]    evt_stat_reg;
	logic [EVT_W-1:0]    evt_stat_next;
	logic [EVT_W-1:0]    evt_en_reg;
	logic [EVT_W-1:0]    evt_en_next;
	logic                irq_reg;
	logic                irq_next;
	logic                sys_rst_reg;
	logic                sys_rst_next;
	logic                wake_reg;
	logic                wake_next;
	logic                wr_take;
	logic                rd_take;
	logic [SHAMT_W-1:0]  shamt;
	logic [CNT_W:0]      limit;
	logic                hit;

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	assign wr_take = avs_write && !wait_reg;
	assign rd_take = avs_read && wait_reg;

	always_comb begin
		wait_next  = 1'b1;
		rdata_next = rdata_reg;
		if ((avs_read || avs_write) && wait_reg) begin
			wait_next = 1'b0;
		end
		if (rd_take) begin
			case (avs_address)
				OFF_CTRL:     rdata_next = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
				OFF_UNLOCK:   rdata_next = {{(DATA_W-1){1'b0}}, lock_reg == LK_OPEN};
				OFF_EVT_STAT: rdata_next = {{(DATA_W-EVT_W){1'b0}}, evt_stat_reg};
				OFF_EVT_EN:   rdata_next = {{(DATA_W-EVT_W){1'b0}}, evt_en_reg};
				OFF_COUNT:    rdata_next = {{(DATA_W-CNT_W){1'b0}}, cnt_reg};
				default:      rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_reg  <= 1'b1;
			rdata_reg <= '0;
		end else begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// Unlock sequence
	// ------------------------------------------------------------
	always_comb begin
		lock_next = lock_reg;
		if (wr_take && avs_address == OFF_UNLOCK && avs_byteenable[0]) begin
			case (lock_reg)
				LK_LOCKED: begin
					lock_next = (avs_writedata[7:0] == UNLOCK_KEY1) ? LK_KEY1 : LK_LOCKED;
				end
				LK_KEY1: begin
					lock_next = (avs_writedata[7:0] == UNLOCK_KEY2) ? LK_KEY2 : LK_LOCKED;
				end
				LK_KEY2: begin
					lock_next = (avs_writedata[7:0] == UNLOCK_KEY3) ? LK_OPEN : LK_LOCKED;
				end
				LK_OPEN: begin
					lock_next = (avs_writedata[7:0] == UNLOCK_KEY1) ? LK_KEY1 : LK_LOCKED;
				end
				default: begin
					lock_next = LK_LOCKED;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_reg <= LK_LOCKED;
		end else begin
			lock_reg <= lock_next;
		end
	end

	// ------------------------------------------------------------
	// Timeout detection
	// ------------------------------------------------------------
	assign shamt = SHAMT_W'(SEL_BASE + SEL_STEP * int'(ctrl_reg.interval_sel));
	assign limit = (CNT_W+1)'(1) << shamt;
	assign hit   = ({1'b0, cnt_reg} == (limit - (CNT_W+1)'(1)));

	// ------------------------------------------------------------
	// Watchdog core
	// ------------------------------------------------------------
	always_comb begin
		ctrl_next     = ctrl_reg;
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		grace_next    = grace_reg;
		rst_cnt_next  = rst_cnt_reg;
		evt_stat_next = evt_stat_reg;
		evt_en_next   = evt_en_reg;
		wake_next     = 1'b0;

		// Software side first, hardware sets below win
		if (ctrl_reg.clear) begin
			ctrl_next.clear = 1'b0;
		end
		if (wr_take && avs_address == OFF_CTRL && lock_reg == LK_OPEN) begin
			if (avs_byteenable[0]) begin
				ctrl_next.enable  = avs_writedata[7];
				ctrl_next.irq_en  = avs_writedata[6];
				ctrl_next.wake_en = avs_writedata[4];
				ctrl_next.reset_en = avs_writedata[1];
				if (avs_writedata[5]) begin
					ctrl_next.wake_flag = 1'b0;
				end
				if (avs_writedata[3]) begin
					ctrl_next.irq_flag = 1'b0;
				end
				if (avs_writedata[2]) begin
					ctrl_next.reset_flag = 1'b0;
				end
				if (avs_writedata[0]) begin
					ctrl_next.clear = 1'b1;
				end
			end
			if (avs_byteenable[1]) begin
				ctrl_next.interval_sel = avs_writedata[CTRL_W-1:LANE_LO_W];
			end
		end
		if (wr_take && avs_address == OFF_EVT_EN && avs_byteenable[0]) begin
			evt_en_next = avs_writedata[EVT_W-1:0];
		end
		if (wr_take && avs_address == OFF_EVT_CLR && avs_byteenable[0]) begin
			evt_stat_next = evt_stat_reg & ~avs_writedata[EVT_W-1:0];
		end

		// Counter and timeout sequence
		case (state_reg)
			WD_RUN: begin
				if (!ctrl_reg.enable) begin
					cnt_next = '0;
				end else if (ctrl_reg.clear) begin
					cnt_next = '0;
				end else begin
					cnt_next = cnt_reg + CNT_W'(1);
					if (hit) begin
						state_next = WD_GRACE;
						grace_next = '0;
						evt_stat_next[EVT_TIMEOUT] = 1'b1;
						if (ctrl_reg.irq_en) begin
							ctrl_next.irq_flag = 1'b1;
						end
						if (ctrl_reg.wake_en && power_down) begin
							ctrl_next.wake_flag = 1'b1;
							wake_next = 1'b1;
							evt_stat_next[EVT_WAKE] = 1'b1;
						end
					end
				end
			end
			WD_GRACE: begin
				if (!ctrl_reg.enable) begin
					cnt_next   = '0;
					state_next = WD_RUN;
				end else if (ctrl_reg.clear) begin
					cnt_next   = '0;
					state_next = WD_RUN;
				end else begin
					cnt_next   = cnt_reg + CNT_W'(1);
					grace_next = grace_reg + GRACE_W'(1);
					if (grace_reg == GRACE_W'(GRACE_CLKS - 1)) begin
						if (ctrl_reg.reset_en) begin
							state_next    = WD_RESET;
							rst_cnt_next  = '0;
							ctrl_next     = CTRL_RESET;
							ctrl_next.reset_flag = 1'b1;
							ctrl_next.wake_flag  = ctrl_reg.wake_flag | ctrl_next.wake_flag;
							evt_stat_next[EVT_RESET] = 1'b1;
						end else begin
							state_next = WD_RUN;
						end
					end
				end
			end
			WD_RESET: begin
				cnt_next     = '0;
				ctrl_next.enable = 1'b0;
				rst_cnt_next = rst_cnt_reg + RST_W'(1);
				if (rst_cnt_reg == RST_W'(RST_CLKS - 1)) begin
					state_next = WD_RUN;
				end
			end
			default: begin
				state_next = WD_RUN;
				cnt_next   = '0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_comb begin
		irq_next     = (ctrl_next.irq_flag && ctrl_next.irq_en) || |(evt_stat_next & evt_en_next);
		sys_rst_next = (state_next == WD_RESET);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg     <= CTRL_RESET;
			state_reg    <= WD_RUN;
			cnt_reg      <= '0;
			grace_reg    <= '0;
			rst_cnt_reg  <= '0;
			evt_stat_reg <= '0;
			evt_en_reg   <= '0;
			irq_reg      <= 1'b0;
			sys_rst_reg  <= 1'b0;
			wake_reg     <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			grace_reg    <= grace_next;
			rst_cnt_reg  <= rst_cnt_next;
			evt_stat_reg <= evt_stat_next;
			evt_en_reg   <= evt_en_next;
			irq_reg      <= irq_next;
			sys_rst_reg  <= sys_rst_next;
			wake_reg     <= wake_next;
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign wdt_irq         = irq_reg;
	assign sys_reset_req   = sys_rst_reg;
	assign wake_req        = wake_reg;

endmodule : wdt_top

// [wdt_monitor.sv]
// Checker of bus answer, reset pulse, wake pulse and interrupt timing.
// Sees only wdt_top ports; bound to wdt_top below.
`timescale 1ns/10ps
module wdt_monitor
	import wdt_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [DATA_W-1:0] avs_readdata,
	input wire logic              avs_waitrequest,
	input wire logic              power_down,
	input wire logic              wdt_irq,
	input wire logic              sys_reset_req,
	input wire logic              wake_req
);
	logic [6:0]  hi_reg;
	logic [6:0]  hi_next;
	logic [10:0] quiet_reg;
	logic [10:0] quiet_next;
	always_comb begin
		hi_next = sys_reset_req ? hi_reg + 7'h01 : 7'h00;
		quiet_next = (quiet_reg == 11'h7FF) ? quiet_reg : quiet_reg + 11'h001;
		if (avs_write && !avs_waitrequest && avs_address == OFF_CTRL)
			quiet_next = 11'h000;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_reg <= 7'h00;
			quiet_reg <= 11'h000;
		end else begin
			hi_reg <= hi_next;
			quiet_reg <= quiet_next;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_answer: assert property (p_answer) else $error("bus answer late");
	property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_one: assert property (p_one) else $error("answer too long");
	property p_hold; !avs_read |=> $stable(avs_readdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_len; $fell(sys_reset_req) |-> hi_reg == RST_CLKS; endproperty
	a_len: assert property (p_len) else $error("reset length wrong");
	property p_grace; $rose(sys_reset_req) |-> quiet_reg >= GRACE_CLKS + 14; endproperty
	a_grace: assert property (p_grace) else $error("reset too early");
	property p_wake; wake_req |=> !wake_req; endproperty
	a_wake: assert property (p_wake) else $error("wake not a pulse");
	property p_wpd; wake_req |-> $past(power_down); endproperty
	a_wpd: assert property (p_wpd) else $error("wake while awake");
	property p_irq; $fell(wdt_irq) |-> $past(avs_write, 2) || $past(avs_write, 3) || sys_reset_req; endproperty
	a_irq: assert property (p_irq) else $error("irq dropped alone");
endmodule : wdt_monitor

bind wdt_top wdt_monitor wdt_monitor_inst (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.power_down(power_down), .wdt_irq(wdt_irq), .sys_reset_req(sys_reset_req), .wake_req(wake_req));

// [test_watchdog_timer_control.sv]
// Self-checking bench of the watchdog block over Avalon-MM.
// Assumes wdt_pkg compiled first; byteenable tied to all lanes.
`timescale 1ns/10ps
module test_watchdog_timer_control;
	import wdt_pkg::*;
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic              power_down = 1'b0;
	logic [DATA_W-1:0] avs_writedata = '0;
	logic [DATA_W-1:0] avs_readdata;
	logic [DATA_W-1:0] rd_val;
	logic              avs_waitrequest, wdt_irq, sys_reset_req, wake_req;
	int                num_errors = 0, total_checks = 0, rst_cnt = 0, wake_cnt = 0, n, s, p;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		rst_cnt <= rst_cnt + sys_reset_req;
		wake_cnt <= wake_cnt + wake_req;
	end
	wdt_top wdt_top_inst (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .power_down(power_down),
		.wdt_irq(wdt_irq), .sys_reset_req(sys_reset_req), .wake_req(wake_req));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q);
		int k;
		k = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		q = avs_readdata;
		if (avs_waitrequest !== 1'b0) begin
			num_errors++;
			final_report();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] q;
		bus(1'b0, a, '0, q);
		chk(q, e);
	endtask : rd
	task automatic unlock();
		wr(OFF_UNLOCK, 32'(UNLOCK_KEY1));
		wr(OFF_UNLOCK, 32'(UNLOCK_KEY2));
		wr(OFF_UNLOCK, 32'(UNLOCK_KEY3));
	endtask : unlock
	task automatic wait_hi(input int w, input int lim);
		n = 0;
		while (n < lim && (w == 0 ? wdt_irq : (w == 1 ? sys_reset_req : wake_req)) !== 1'b1) begin
			@(negedge clk);
			n++;
		end
		if (n >= lim) begin
			num_errors++;
			final_report();
		end
	endtask : wait_hi
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(OFF_CTRL, 32'h0000_0700);
		rd(8'h20, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0080);
		rd(OFF_CTRL, 32'h0000_0700);
		unlock();
		rd(OFF_UNLOCK, 32'h0000_0001);
		wr(OFF_CTRL, 32'hFFFF_F800);
		rd(OFF_CTRL, 32'h0000_0000);
		$display("lock test done");
		for (s = 0; s < 3; s++) begin
			p = 1 << (SEL_BASE + SEL_STEP * s);
			wr(OFF_CTRL, 32'(s << 8) | 32'h0000_00C0);
			wait_hi(0, p + 20);
			chk(32'(n >= p - 1 && n <= p + 3), 32'h1);
			wr(OFF_CTRL, 32'(s << 8) | 32'h0000_00C0);
			rd(OFF_CTRL, 32'(s << 8) | 32'h0000_00C8);
			wr(OFF_CTRL, 32'h0000_0008);
			rd(OFF_CTRL, 32'h0000_0000);
			rd(OFF_COUNT, 32'h0000_0000);
		end
		$display("interval test done");
		wr(OFF_EVT_CLR, 32'h0000_0007);
		wr(OFF_CTRL, 32'h0000_0080);
		repeat (40) @(negedge clk);
		chk(32'(wdt_irq), 32'h0);
		rd(OFF_CTRL, 32'h0000_0080);
		rd(OFF_EVT_STAT, 32'h0000_0001);
		wr(OFF_EVT_EN, 32'h0000_0001);
		wait_hi(0, 10);
		wr(OFF_EVT_EN, 32'h0000_0000);
		repeat (2) @(negedge clk);
		chk(32'(wdt_irq), 32'h0);
		wr(OFF_EVT_EN, 32'h0000_0001);
		wait_hi(0, 10);
		wr(OFF_EVT_CLR, 32'h0000_0001);
		repeat (2) @(negedge clk);
		chk(32'(wdt_irq), 32'h0);
		rd(OFF_EVT_STAT, 32'h0000_0000);
		$display("interrupt test done");
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0080);
		for (s = 0; s < 6; s++) begin
			repeat (8) @(posedge clk);
			wr(OFF_CTRL, 32'h0000_0081);
		end
		rd(OFF_CTRL, 32'h0000_0080);
		bus(1'b0, OFF_COUNT, '0, rd_val);
		chk(32'(rd_val < 8), 32'h1);
		rd(OFF_EVT_STAT, 32'h0000_0000);
		$display("clear test done");
		power_down <= 1'b1;
		wr(OFF_CTRL, 32'h0000_0010);
		wr(OFF_CTRL, 32'h0000_0090);
		wait_hi(2, 40);
		rd(OFF_CTRL, 32'h0000_00B0);
		wr(OFF_CTRL, 32'h0000_0020);
		rd(OFF_CTRL, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0080);
		repeat (40) @(negedge clk);
		chk(32'(wake_cnt), 32'h1);
		power_down <= 1'b0;
		$display("wake test done");
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0080);
		repeat (1100) @(negedge clk);
		chk(32'(rst_cnt), 32'h0);
		rd(OFF_CTRL, 32'h0000_0080);
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_EVT_CLR, 32'h0000_0007);
		wr(OFF_CTRL, 32'h0000_0082);
		wait_hi(1, 1100);
		chk(32'(n >= 1038 && n <= 1044), 32'h1);
		repeat (70) @(negedge clk);
		chk(32'(rst_cnt), 32'(RST_CLKS));
		rd(OFF_CTRL, 32'h0000_0704);
		rd(OFF_EVT_STAT, 32'h0000_0005);
		unlock();
		wr(OFF_CTRL, 32'h0000_0704);
		rd(OFF_CTRL, 32'h0000_0700);
		$display("reset test done");
		final_report();
	end
endmodule : test_watchdog_timer_control
